//--- bench/opw_host.sv
// Model of the external programmer and of the CPU that drive the writer's ports.
`timescale 1ns/1ps
`include "opw_defs.svh"
module opw_host #(
   parameter int START_WAIT = 20
) (
   input  wire logic        clk,
   output logic      [3:0]  reg_addr,
   output logic      [7:0]  reg_wdata,
   output logic             reg_wr,
   output logic             reg_rd,
   input  wire logic [7:0]  reg_rdata,
   output logic             xd_wr,
   output logic      [15:0] xd_addr,
   output logic      [7:0]  xd_wdata
);
   // ----------------------------------------
   // Port access
   // ----------------------------------------
   // Idle values at time zero; data lines toggle once released so stale data is never read as good.
   initial begin
      reg_addr  = 4'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      xd_wr     = 1'b0;
      xd_addr   = 16'h0000;
      xd_wdata  = 8'h00;
   end

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
      reg_wdata <= ~d;
   endtask

   // One-cycle register read; the data stand only in the following cycle.
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // One external-data write from the CPU.
   task automatic xwr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      xd_addr  <= a;
      xd_wdata <= d;
      xd_wr    <= 1'b1;
      @(posedge clk);
      xd_wr    <= 1'b0;
      xd_wdata <= ~d;
   endtask

   // Settling time after the reset pin, shortened by the parameter.
   task automatic start_wait();
      repeat (START_WAIT) @(posedge clk);
   endtask

   // Core reset hold, then the two-step entry.
   task automatic enter(input logic [7:0] second);
      wr(`OPW_A_DEVICE_CONTROL, 8'h04);
      wr(`OPW_A_MPC, `OPW_MPC_ARM);
      wr(`OPW_A_MPC, second);
   endtask

   task automatic set_addr(input logic [15:0] a);
      wr(`OPW_A_ADDRH, a[15:8]);
      wr(`OPW_A_ADDRL, a[7:0]);
   endtask

   // Status polling is bounded so a stuck busy flag cannot hang the model.
   task automatic poll(output logic [7:0] st);
      int n;
      n = 0;
      rd(`OPW_A_STATUS, st);
      while (st[0] !== 1'b0 && n < 300) begin
         rd(`OPW_A_STATUS, st);
         n++;
      end
   endtask

   task automatic prog_byte(input logic [15:0] a, input logic [7:0] d, output logic [7:0] st);
      set_addr(a);
      wr(`OPW_A_DATA, d);
      poll(st);
   endtask

   task automatic peek(input logic [15:0] a, output logic [7:0] d);
      set_addr(a);
      rd(`OPW_A_DATA, d);
   endtask

   task automatic leave();
      wr(`OPW_A_MPC, `OPW_MPC_ARM);
      wr(`OPW_A_MPC, `OPW_MPC_OFF);
   endtask

   // Write enable, keys and programming enable, once for every byte.
   // Clock, interrupt, monitor, prefetch and pin setup lie outside this block.
   task automatic unlock();
      wr(`OPW_A_PSC, 8'h01);
      wr(`OPW_A_KEY, `OPW_KEY_FIRST);
      wr(`OPW_A_KEY, `OPW_KEY_SECOND);
      wr(`OPW_A_IAP, 8'h80);
   endtask

   // Shut down in-app programming; 20 cycles make the 1 us pause.
   task automatic iap_end();
      wr(`OPW_A_IAP, 8'h00);
      wr(`OPW_A_PSC, 8'h00);
      repeat (20) @(posedge clk);
      wr(`OPW_A_IAP, 8'h40);
   endtask
endmodule

//--- bench/opw_top_tb.sv
// Self-checking testbench of the OTP writer.
`timescale 1ns/1ps
`include "opw_defs.svh"
module opw_top_tb;
   logic        clk;
   logic        arst_n;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        xd_wr;
   logic [15:0] xd_addr;
   logic [7:0]  xd_wdata;
   logic        core_reset_hold;
   logic        device_reset;
   logic        prog_mode;
   logic        prog_busy;
   logic        prog_error;
   logic        prog_hw_disable;
   logic [7:0]  v;
   logic        seen;
   int          num_errors = 0;
   int          checks = 0;

   // ----------------------------------------
   // Clock, design and host
   // ----------------------------------------
   // A 50 ns period gives the 20 MHz core clock.
   initial clk = 1'b0;
   always #25 clk = ~clk;

   opw_top opw_top_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xd_wr(xd_wr), .xd_addr(xd_addr),
      .xd_wdata(xd_wdata), .core_reset_hold(core_reset_hold), .device_reset(device_reset),
      .prog_mode(prog_mode), .prog_busy(prog_busy), .prog_error(prog_error),
      .prog_hw_disable(prog_hw_disable));

   opw_host #(.START_WAIT(20)) opw_host_i (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xd_wr(xd_wr), .xd_addr(xd_addr),
      .xd_wdata(xd_wdata));

   // Output flags packed as: core hold, device reset, mode, busy, error, hw disable.
   function automatic logic [7:0] flags();
      return {2'b00, core_reset_hold, device_reset, prog_mode, prog_busy, prog_error, prog_hw_disable};
   endfunction

   task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic chk1(input string nm, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", nm, exp, got);
      end
   endtask

   // Lets two edges land so registered flags are settled.
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   // Looks for busy over four cycles; a refused write must leave it low throughout.
   task automatic wait_rise(output logic s);
      s = 1'b0;
      repeat (4) begin
         @(posedge clk);
         #1;
         if (prog_busy === 1'b1) s = 1'b1;
      end
   endtask

   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask

   task automatic summarize();
      $display("checks %0d num_errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   // Watchdog sized well beyond the four busy periods of the run.
   initial begin
      #2_000_000;
      num_errors++;
      $display("ERROR watchdog expected finish seen timeout");
      summarize();
   end

   // Main sequence: debug path, in-app path, readback, device reset, second reset.
   initial begin
      arst_n = 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      opw_host_i.start_wait();
      #1;
      chk8("flags", 8'h00, flags());
      opw_host_i.rd(`OPW_A_STATUS, v);
      chk8("status", 8'h00, v);
      opw_host_i.wr(`OPW_A_DEVICE_CONTROL, 8'h04);
      opw_host_i.set_addr(16'h0010);
      opw_host_i.wr(`OPW_A_DATA, 8'h77);
      wait_rise(seen);
      chk1("busy", 1'b0, seen);
      opw_host_i.wr(`OPW_A_MPC, `OPW_MPC_ARM);
      opw_host_i.wr(`OPW_A_MPC, 8'h13);
      settle();
      chk8("flags", 8'h20, flags());
      opw_host_i.enter(`OPW_MPC_GO);
      settle();
      chk8("flags", 8'h28, flags());
      done("entry");
      opw_host_i.set_addr(16'h0010);
      opw_host_i.wr(`OPW_A_DATA, 8'h3C);
      wait_rise(seen);
      chk1("busy", 1'b1, seen);
      opw_host_i.rd(`OPW_A_ADDRL, v);
      chk8("addr_low", 8'h11, v);
      opw_host_i.poll(v);
      chk8("status", 8'h04, v);
      opw_host_i.wr(`OPW_A_DATA, 8'hC3);
      opw_host_i.poll(v);
      chk8("status", 8'h04, v);
      opw_host_i.peek(16'h0010, v);
      chk8("byte_10", 8'h3C, v);
      opw_host_i.peek(16'h0011, v);
      chk8("byte_11", 8'hC3, v);
      opw_host_i.prog_byte(16'h0010, 8'h00, v);
      chk8("status", 8'h06, v);
      opw_host_i.peek(16'h0010, v);
      chk8("byte_10", 8'h3C, v);
      opw_host_i.leave();
      settle();
      chk8("flags", 8'h22, flags());
      done("debug");
      opw_host_i.xwr(16'h0020, 8'h5A);
      wait_rise(seen);
      chk1("busy", 1'b0, seen);
      opw_host_i.unlock();
      opw_host_i.rd(`OPW_A_STATUS, v);
      chk8("status", 8'h0A, v);
      opw_host_i.xwr(16'h0020, 8'h5A);
      wait_rise(seen);
      chk1("busy", 1'b1, seen);
      chk8("flags", 8'h24, flags());
      opw_host_i.poll(v);
      chk8("status", 8'h00, v);
      opw_host_i.xwr(16'h0021, 8'hA5);
      wait_rise(seen);
      chk1("busy", 1'b0, seen);
      opw_host_i.iap_end();
      settle();
      chk8("flags", 8'h21, flags());
      opw_host_i.unlock();
      opw_host_i.xwr(16'h0023, 8'h11);
      wait_rise(seen);
      chk1("busy", 1'b0, seen);
      done("in_app");
      opw_host_i.enter(`OPW_MPC_GO_OLD);
      settle();
      chk8("flags", 8'h29, flags());
      opw_host_i.rd(`OPW_A_MPC, v);
      chk8("mem_prog_ctl", `OPW_MPC_GO, v);
      opw_host_i.wr(`OPW_A_MPC, `OPW_MPC_ARM);
      opw_host_i.wr(`OPW_A_MPC, 8'h13);
      settle();
      chk8("flags", 8'h29, flags());
      opw_host_i.rd(`OPW_A_IAP, v);
      chk8("in_app_ctl", 8'hC0, v);
      opw_host_i.rd(`OPW_A_PSC, v);
      chk8("store_ctl", 8'h01, v);
      opw_host_i.rd(`OPW_A_DEVICE_CONTROL, v);
      chk8("dev_ctl", 8'h04, v);
      opw_host_i.peek(16'h0020, v);
      chk8("byte_20", 8'h5A, v);
      opw_host_i.peek(16'h0021, v);
      chk8("byte_21", `OPW_BLANK, v);
      opw_host_i.peek(16'h0023, v);
      chk8("byte_23", `OPW_BLANK, v);
      opw_host_i.leave();
      opw_host_i.wr(`OPW_A_DEVICE_CONTROL, 8'h02);
      settle();
      chk8("flags", 8'h11, flags());
      opw_host_i.wr(`OPW_A_DEVICE_CONTROL, 8'h00);
      settle();
      chk8("flags", 8'h01, flags());
      done("dev_reset");
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      settle();
      chk8("flags", 8'h00, flags());
      done("second_reset");
      summarize();
   end
endmodule

//--- rtl/opw_defs.svh
// Register offsets, field positions, key values and timing counts of the OTP writer.
`ifndef OPW_DEFS_SVH
`define OPW_DEFS_SVH

// ----------------------------------------
// Register offsets on the plain register port
// ----------------------------------------
`define OPW_A_DEVICE_CONTROL   4'h0
`define OPW_A_MPC      4'h1
`define OPW_A_ADDRH    4'h2
`define OPW_A_ADDRL    4'h3
`define OPW_A_DATA     4'h4
`define OPW_A_STATUS   4'h5
`define OPW_A_PSC      4'h6
`define OPW_A_KEY      4'h7
`define OPW_A_IAP      4'h8

// ----------------------------------------
// Command values and keys
// ----------------------------------------
`define OPW_MPC_ARM    8'h40
`define OPW_MPC_GO     8'h4A
`define OPW_MPC_GO_OLD 8'h58
`define OPW_MPC_OFF    8'h00
`define OPW_KEY_FIRST  8'hA5
`define OPW_KEY_SECOND 8'hF1
`define OPW_BLANK      8'hFF

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OPW_DC_CORE_RST 2
`define OPW_DC_DEV_RST  1
`define OPW_PSC_WE      0
`define OPW_IAP_EN      7
`define OPW_IAP_HWD     6
`define OPW_DC_RESET    8'h00

// ----------------------------------------
// Timing: byte programming time and its count of 50 ns cycles
// ----------------------------------------
`define OPW_CLK_NS       50
`define OPW_PROG_TIME_NS 10000
`define OPW_PROG_CYC     ((`OPW_PROG_TIME_NS + `OPW_CLK_NS - 1) / `OPW_CLK_NS)

`endif

//--- rtl/opw_if.sv
// Request and answer signals between the control logic and the programming engine.
`timescale 1ns/1ps
interface opw_if;
   logic        req;
   logic [15:0] addr;
   logic [7:0]  data;
   logic        busy;
   logic        err;
   logic [15:0] raddr;
   logic [7:0]  rdata;

   modport eng (input req, input addr, input data, input raddr, output busy, output err, output rdata);
   modport ctl (output req, output addr, output data, output raddr, input busy, input err, input rdata);
endinterface

//--- rtl/opw_pkg.sv
// Types shared by the OTP writer modules.
package opw_pkg;

   // Program mode entry and exit sequence.
   typedef enum logic [1:0] {EP_IDLE, EP_ARM, EP_PROG, EP_DISARM} opw_ep_t;

   // Key unlock progress for in-application writes.
   typedef enum logic [1:0] {KEY_LOCK, KEY_HALF, KEY_OPEN} opw_key_t;

   // Whole state of the control module.
   typedef struct packed {
      logic [7:0]  dev_ctl;
      opw_ep_t     ep;
      logic [15:0] addr;
      logic        program_store_write_enable;
      opw_key_t    key;
      logic        iap_en;
      logic        hwdis;
      logic        err;
      logic [7:0]  rdata;
   } opw_top_t;

   // Sequencer state of the byte programming engine; the array and written marks are kept apart.
   typedef struct packed {
      logic        busy;
      logic [7:0]  cnt;
      logic        fail;
      logic [15:0] a;
      logic [7:0]  d;
   } opw_eng_t;

endpackage

//--- rtl/opw_prog.sv
// Byte programming engine holding the one-time-programmable array.
`timescale 1ns/1ps
`include "opw_defs.svh"
module opw_prog (
   input  wire logic clk,
   input  wire logic arst_n,
   opw_if.eng        bus
);
   opw_pkg::opw_eng_t s;
   opw_pkg::opw_eng_t n;
   logic              fin;
   logic [7:0]        mem [0:65535];
   logic [65535:0]    used_r;

   // ----------------------------------------
   // Programming sequencer
   // ----------------------------------------

   // A request is taken only when idle; a location already written fails instead of being changed.
   always_comb begin
      n   = s;
      fin = 1'b0;
      if (!s.busy) begin
         if (bus.req) begin
            n.busy = 1'b1;
            n.cnt  = 8'(`OPW_PROG_CYC - 1);
            n.fail = used_r[bus.addr];
            n.a    = bus.addr;
            n.d    = bus.data;
         end
      end else if (s.cnt == 8'h00) begin
         n.busy = 1'b0;
         fin    = 1'b1;
      end else begin
         n.cnt = s.cnt - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // The array itself has no reset; the written marks say which bytes hold data.
   always_ff @(posedge clk) begin
      if (fin && !s.fail) begin
         mem[s.a] <= s.d;
      end
   end

   // Written marks clear only at power-up reset, modelling a blank part.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         used_r <= '0;
      end else if (fin && !s.fail) begin
         used_r[s.a] <= 1'b1;
      end
   end

   // Answers: busy from the register, error as a one-cycle pulse at the end.
   assign bus.busy  = s.busy;
   assign bus.err   = fin & s.fail;
   assign bus.rdata = used_r[bus.raddr] ? mem[bus.raddr] : `OPW_BLANK;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   rewrite_fails_a: assert property ((bus.req && !s.busy && used_r[bus.addr]) |-> ##[1:200] bus.err)
      else $error("rewrite of a written byte did not fail");
   busy_hold_a: assert property ((bus.req && !s.busy) |=> s.busy [*8])
      else $error("engine did not stay busy after a request");
endmodule

//--- rtl/opw_top.sv
// OTP program memory writer: debug-port program mode and in-application byte writes.
`timescale 1ns/1ps
`include "opw_defs.svh"
// Summary of operation
// - Each byte programs once; rewrites fail.
// - Program mode needs 0x40 then 0x4A or 0x58.
// - Data write programs byte, address increments.
// - Failed byte write sets error flag.
// - Program mode exits on 0x40 then 0x00.
// - Device control 0x02 then 0x00 resets.
// - One byte written per external write.
// - One unlock allows only one byte.
// - Writing 0x40 sets hardware disable bit.
module opw_top (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        xd_wr,
   input  wire logic [15:0] xd_addr,
   input  wire logic [7:0]  xd_wdata,
   output logic             core_reset_hold,
   output logic             device_reset,
   output logic             prog_mode,
   output logic             prog_busy,
   output logic             prog_error,
   output logic             prog_hw_disable
);
   opw_pkg::opw_top_t s;
   opw_pkg::opw_top_t n;
   logic              ep_fire;
   logic              iap_fire;
   logic              iap_ok;

   opw_if bus ();

   // ----------------------------------------
   // Programming engine
   // ----------------------------------------

   // The engine owns the array and the busy timing.
   opw_prog opw_prog_i (
      .clk    (clk),
      .arst_n (arst_n),
      .bus    (bus.eng)
   );

   // Reads of the data register show the byte at the current address.
   assign bus.raddr = s.addr;

   // An in-application write must see write enable, both keys, the enable and no hardware disable.
   assign iap_ok = s.program_store_write_enable && (s.key == opw_pkg::KEY_OPEN) && s.iap_en && !s.hwdis;

   // ----------------------------------------
   // Register writes, sequences and requests
   // ----------------------------------------

   // All next-state logic for the control side sits in one process.
   always_comb begin
      n        = s;
      ep_fire  = 1'b0;
      iap_fire = 1'b0;
      bus.req  = 1'b0;
      bus.addr = s.addr;
      bus.data = reg_wdata;
      n.rdata  = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            `OPW_A_DEVICE_CONTROL: begin
               n.dev_ctl = reg_wdata;
            end
            `OPW_A_MPC: begin
               case (s.ep)
                  opw_pkg::EP_IDLE: begin
                     n.ep = (reg_wdata == `OPW_MPC_ARM) ? opw_pkg::EP_ARM : opw_pkg::EP_IDLE;
                  end
                  opw_pkg::EP_ARM: begin
                     // Both second values are accepted so older programmers still work.
                     if (reg_wdata == `OPW_MPC_GO || reg_wdata == `OPW_MPC_GO_OLD) begin
                        n.ep = opw_pkg::EP_PROG;
                     end else begin
                        n.ep = opw_pkg::EP_IDLE;
                     end
                  end
                  opw_pkg::EP_PROG: begin
                     n.ep = (reg_wdata == `OPW_MPC_ARM) ? opw_pkg::EP_DISARM : opw_pkg::EP_PROG;
                  end
                  opw_pkg::EP_DISARM: begin
                     n.ep = (reg_wdata == `OPW_MPC_OFF) ? opw_pkg::EP_IDLE : opw_pkg::EP_PROG;
                  end
                  default: begin
                     n.ep = opw_pkg::EP_IDLE;
                  end
               endcase
            end
            `OPW_A_ADDRH: begin
               n.addr[15:8] = reg_wdata;
            end
            `OPW_A_ADDRL: begin
               n.addr[7:0] = reg_wdata;
            end
            `OPW_A_DATA: begin
               // Writes while busy or outside program mode are dropped.
               ep_fire = (s.ep == opw_pkg::EP_PROG) && !bus.busy;
            end
            `OPW_A_PSC: begin
               n.program_store_write_enable = reg_wdata[`OPW_PSC_WE];
            end
            `OPW_A_KEY: begin
               // A wrong key, or any key after unlock, locks again.
               case (s.key)
                  opw_pkg::KEY_LOCK: begin
                     n.key = (reg_wdata == `OPW_KEY_FIRST) ? opw_pkg::KEY_HALF : opw_pkg::KEY_LOCK;
                  end
                  opw_pkg::KEY_HALF: begin
                     n.key = (reg_wdata == `OPW_KEY_SECOND) ? opw_pkg::KEY_OPEN : opw_pkg::KEY_LOCK;
                  end
                  default: begin
                     n.key = opw_pkg::KEY_LOCK;
                  end
               endcase
            end
            `OPW_A_IAP: begin
               n.iap_en = reg_wdata[`OPW_IAP_EN];
               // Hardware disable is one-way until reset, so a stray write cannot revive the pin.
               if (reg_wdata[`OPW_IAP_HWD]) begin
                  n.hwdis = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Debug-port data write wins over an in-application write in the same cycle.
      if (ep_fire) begin
         bus.req = 1'b1;
         n.addr  = s.addr + 16'h0001;
         n.err   = 1'b0;
      end else if (xd_wr && iap_ok && !bus.busy) begin
         iap_fire = 1'b1;
         bus.req  = 1'b1;
         bus.addr = xd_addr;
         bus.data = xd_wdata;
         n.err    = 1'b0;
      end
      // Any external write consumes the unlock, even one that was dropped.
      if (xd_wr && s.key == opw_pkg::KEY_OPEN) begin
         n.key = opw_pkg::KEY_LOCK;
      end
      // A failure report beats the clear of a new start.
      if (bus.err) begin
         n.err = 1'b1;
      end
      if (reg_rd) begin
         case (reg_addr)
            `OPW_A_DEVICE_CONTROL: n.rdata = s.dev_ctl;
            `OPW_A_MPC:    n.rdata = (s.ep == opw_pkg::EP_PROG) ? `OPW_MPC_GO : `OPW_MPC_OFF;
            `OPW_A_ADDRH:  n.rdata = s.addr[15:8];
            `OPW_A_ADDRL:  n.rdata = s.addr[7:0];
            `OPW_A_DATA:   n.rdata = bus.rdata;
            `OPW_A_STATUS: n.rdata = {4'h0, s.key == opw_pkg::KEY_OPEN, prog_mode, s.err, bus.busy};
            `OPW_A_PSC:    n.rdata = {7'h00, s.program_store_write_enable};
            `OPW_A_IAP:    n.rdata = {s.iap_en, s.hwdis, 6'h00};
            default:       n.rdata = 8'h00;
         endcase
      end
   end

   // State register; reset leaves the array locked and program mode off.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         s         <= '0;
         s.dev_ctl <= `OPW_DC_RESET;
         s.ep      <= opw_pkg::EP_IDLE;
         s.key     <= opw_pkg::KEY_LOCK;
      end else begin
         s <= n;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   // Reset controls stand as levels; device_reset is only an output and does not reset this block.
   assign core_reset_hold = s.dev_ctl[`OPW_DC_CORE_RST];
   assign device_reset    = s.dev_ctl[`OPW_DC_DEV_RST];
   assign prog_mode       = (s.ep == opw_pkg::EP_PROG) || (s.ep == opw_pkg::EP_DISARM);
   assign prog_busy       = bus.busy;
   assign prog_error      = s.err;
   assign prog_hw_disable = s.hwdis;
   assign reg_rdata       = s.rdata;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence arm_s;
      reg_wr && reg_addr == `OPW_A_MPC && reg_wdata == `OPW_MPC_ARM;
   endsequence
   sequence go_s;
      reg_wr && reg_addr == `OPW_A_MPC && reg_wdata == `OPW_MPC_GO;
   endsequence
   // A register master leaves one idle cycle between writes, so the two steps sit two cycles apart.
   sequence gap_s;
      !reg_wr;
   endsequence

   entry_seq_a: assert property ((s.ep == opw_pkg::EP_IDLE) ##0 arm_s ##1 gap_s ##1 go_s |=> prog_mode)
      else $error("two-step entry did not reach program mode");
   entry_src_a: assert property ($rose(prog_mode) |-> $past(s.ep) == opw_pkg::EP_ARM)
      else $error("program mode entered without the first step");
   mode_exit_a: assert property ($fell(prog_mode) |-> $past(s.ep) == opw_pkg::EP_DISARM && $past(reg_wdata) == `OPW_MPC_OFF)
      else $error("program mode left without the exit sequence");
   addr_inc_a: assert property (ep_fire |=> s.addr == $past(s.addr) + 16'h0001)
      else $error("address did not step by one");
   err_flag_a: assert property (bus.err |=> prog_error ##1 (prog_error || $past(bus.req)))
      else $error("error flag not set after a failed write");
   one_shot_a: assert property (iap_fire |=> s.key == opw_pkg::KEY_LOCK && !iap_fire)
      else $error("unlock allowed more than one byte");
   locked_drop_a: assert property ((xd_wr && s.key != opw_pkg::KEY_OPEN) |-> !bus.req || ep_fire)
      else $error("locked external write reached the array");
   hw_dis_a: assert property ((reg_wr && reg_addr == `OPW_A_IAP && reg_wdata[6]) |=> prog_hw_disable [*4])
      else $error("hardware disable did not set");
   dev_rst_a: assert property ((reg_wr && reg_addr == `OPW_A_DEVICE_CONTROL) |=> device_reset == $past(reg_wdata[1]))
      else $error("device reset control did not follow the write");
endmodule
